// File: verilog/rbs_system_control.sv
// Reset hold, boot decision, memory decode and system control registers
`timescale 1ns/100ps
// What this block does
// - Hold reset 65536 cycles after supply good
// - External low reset forces full reset
// - Reset empties stacks, masks irqs, clears mode
// - Fetch starts at monitor entry after reset
// - Boot flag set: jump to user start
// - Boot flag clear: load from external device
// - Boot flag set blocks external access
// - Full-init clear erases whole flash first
// - Second routine clears flag, keeps program
// - Flash has sectors of 256, 256, 3584
// - Sectors mapped consecutively in program space
// - Peripheral registers at data base address
// - Nonvolatile user bytes read zero erased
// - Cycle clock output at half input
// - Bit 10 selects serial port pins
// - Wait control resets all ones
// - Eleven peripheral irqs merged, all maskable
module rbs_system_control
  import rbs_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    srst,
  input  wire logic                    supplyLowN,
  input  wire logic                    resetPinN,
  input  wire logic                    bootFlashFlag,
  input  wire logic                    flashEraseDone,
  input  wire logic                    clearBootFullReq,
  input  wire logic                    clearBootKeepReq,
  input  wire logic [13:0]             progAddr,
  input  wire logic [13:0]             dataAddr,
  input  wire logic                    dataWr,
  input  wire logic                    dataRd,
  input  wire logic [15:0]             dataWrData,
  input  wire logic [NumIrqSrc-1:0]    irqReq,
  input  wire logic [NumIrqSrc-1:0]    irqMask,
  input  wire logic                    extAccessReq,
  output logic                         coreResetN,
  output logic                         stacksEmpty,
  output logic                         irqMaskAll,
  output logic                         modeStatusClr,
  output logic                         bootVectorValid,
  output logic [13:0]                  bootVector,
  output logic                         extBootStart,
  output logic                         extAccessGrant,
  output logic                         fullEraseReq,
  output logic                         bootClearPulse,
  output logic [1:0]                   flashSector,
  output logic [11:0]                  flashWordAddr,
  output logic                         periphSel,
  output logic [15:0]                  dataRdData,
  output logic                         serialPortMode,
  output logic [15:0]                  waitStateCtl,
  output logic                         peripheralIrqLine,
  output logic [3:0]                   irqVector,
  output logic                         irqPending,
  output logic                         cycleClockOut,
  output logic [7:0]                   nvUserByte
);

  logic                 supSync1_r, supSync2_r, pinSync1_r, pinSync2_r;
  logic [PorCntW-1:0]   porCnt_r;
  logic                 porDone_r;
  logic [PorCntW:0]     supGoodCnt_r;
  logic                 inReset;
  logic                 inReset_r;
  logic                 bootSeen_r;
  logic                 clearPending_r;
  logic [15:0]          sysCtl_r, waitCtl_r;
  logic [NumIrqSrc-1:0] irqLive;
  logic [3:0]           vecNxt;
  logic                 clkDiv_r;

  // Two-flop synchronisers for pins from outside the clock domain
  always_ff @(posedge clk) begin
    supSync1_r <= supplyLowN;
    supSync2_r <= supSync1_r;
    pinSync1_r <= resetPinN;
    pinSync2_r <= pinSync1_r;
  end

  // Hold counter restarts whenever supply dips
  // Pin reset leaves the count alone; only a supply dip or srst restarts the hold
  always_ff @(posedge clk) begin
    if (srst || !supSync2_r) begin
      porCnt_r  <= '0;
      porDone_r <= 1'b0;
    end else if (!porDone_r) begin
      porCnt_r  <= porCnt_r + 1'b1;
      porDone_r <= (porCnt_r == PorCntW'(PorHoldCycles - 1));
    end
  end

  // Check-only: cycles of good supply, saturating once the hold is covered
  always_ff @(posedge clk) begin
    if (srst || !supSync2_r) begin
      supGoodCnt_r <= '0;
    end else if (!supGoodCnt_r[PorCntW]) begin
      supGoodCnt_r <= supGoodCnt_r + 1'b1;
    end
  end

  assign inReset = !porDone_r || !pinSync2_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      coreResetN <= 1'b0;
      inReset_r  <= 1'b1;
    end else begin
      coreResetN <= !inReset;
      inReset_r  <= inReset;
    end
  end

  assign stacksEmpty   = !coreResetN;
  assign irqMaskAll    = !coreResetN;
  assign modeStatusClr = !coreResetN;

  // Boot decision one cycle after reset leaves
  always_ff @(posedge clk) begin
    if (srst || inReset) begin
      bootSeen_r      <= 1'b0;
      bootVectorValid <= 1'b0;
      bootVector      <= MonitorEntry;
      extBootStart    <= 1'b0;
    end else if (!bootSeen_r) begin
      bootSeen_r      <= 1'b1;
      bootVectorValid <= 1'b1;
      bootVector      <= bootFlashFlag ? UserAppStart : MonitorEntry;
      extBootStart    <= !bootFlashFlag;
    end else begin
      bootVectorValid <= 1'b0;
      extBootStart    <= 1'b0;
    end
  end

  assign extAccessGrant = extAccessReq && !bootFlashFlag && coreResetN;

  // Full-init path waits for erase before clearing flag
  always_ff @(posedge clk) begin
    if (srst || inReset) begin
      clearPending_r <= 1'b0;
      fullEraseReq   <= 1'b0;
      bootClearPulse <= 1'b0;
    end else begin
      bootClearPulse <= 1'b0;
      if (clearBootFullReq && !clearPending_r) begin
        clearPending_r <= 1'b1;
        fullEraseReq   <= 1'b1;
      end else if (clearPending_r && flashEraseDone) begin
        clearPending_r <= 1'b0;
        fullEraseReq   <= 1'b0;
        bootClearPulse <= 1'b1;
      end else if (clearBootKeepReq && !clearPending_r) begin
        bootClearPulse <= 1'b1;
      end
    end
  end

  // Program decode: sector and word offset in a 4096-word array
  always_comb begin
    flashWordAddr = progAddr[11:0] - FlashSec0Base[11:0];
    if (progAddr >= FlashSec0Base && progAddr <= FlashSec0Last) begin
      flashSector = RBS_SEC0;
    end else if (progAddr >= FlashSec1Base && progAddr <= FlashSec1Last) begin
      flashSector = RBS_SEC1;
    end else if (progAddr >= FlashSec2Base && progAddr <= FlashSec2Last) begin
      flashSector = RBS_SEC2;
    end else begin
      flashSector = RBS_NOSEC;
    end
  end

  assign periphSel = dataAddr >= PeriphBase && dataAddr <= PeriphLast;
  // Erased storage reads zero; this block has no path to program it
  assign nvUserByte = NvByteErased;

  // System control registers at top of data memory
  always_ff @(posedge clk) begin
    if (srst || inReset) begin
      sysCtl_r  <= SysCtlReset;
      waitCtl_r <= WaitCtlReset;
    end else if (dataWr) begin
      if (dataAddr == SysCtlAddr) begin
        sysCtl_r <= dataWrData;
      end
      if (dataAddr == WaitCtlAddr) begin
        waitCtl_r <= dataWrData;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      dataRdData <= 16'h0000;
    end else if (dataRd && dataAddr == SysCtlAddr) begin
      dataRdData <= sysCtl_r;
    end else if (dataRd && dataAddr == WaitCtlAddr) begin
      dataRdData <= waitCtl_r;
    end else begin
      dataRdData <= 16'h0000;
    end
  end

  assign serialPortMode = sysCtl_r[SerialSelBit];
  assign waitStateCtl   = waitCtl_r;

  // Upper sources are peripherals; fixed priority, lowest index wins
  assign irqLive           = irqReq & irqMask & {NumIrqSrc{coreResetN}};
  assign peripheralIrqLine = |irqLive[NumIrqSrc-1:NumCoreIrq];

  always_comb begin
    vecNxt = 4'h0;
    for (int i = NumIrqSrc - 1; i >= 0; i--) begin
      if (irqLive[i]) begin
        vecNxt = 4'(i);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irqVector  <= 4'h0;
      irqPending <= 1'b0;
    end else begin
      irqVector  <= vecNxt;
      irqPending <= |irqLive;
    end
  end

  // Cycle clock is clk itself; output is a clk/2 marker since a clock can't be a data flop
  always_ff @(posedge clk) begin
    if (srst) begin
      clkDiv_r <= 1'b0;
    end else begin
      clkDiv_r <= !clkDiv_r;
    end
  end
  assign cycleClockOut = clkDiv_r;

  // Properties run on clk; srst masks them all
  chk_por_hold: assert property (@(posedge clk) disable iff (srst)
    !supSync2_r |=> ##1 !coreResetN)
    else $error("reset released too early");
  chk_pin_reset: assert property (@(posedge clk) disable iff (srst)
    !pinSync2_r |=> !coreResetN)
    else $error("pin reset ignored");
  chk_reset_effects: assert property (@(posedge clk) disable iff (srst)
    !coreResetN |-> stacksEmpty && irqMaskAll && modeStatusClr && !peripheralIrqLine)
    else $error("reset effects missing");
  chk_boot_flash: assert property (@(posedge clk) disable iff (srst)
    bootVectorValid && $past(bootFlashFlag) |-> bootVector == UserAppStart && !extBootStart)
    else $error("wrong flash boot vector");
  chk_boot_ext: assert property (@(posedge clk) disable iff (srst)
    bootVectorValid && !$past(bootFlashFlag) |-> bootVector == MonitorEntry && extBootStart)
    else $error("wrong external boot vector");
  chk_lock_access: assert property (@(posedge clk) disable iff (srst)
    bootFlashFlag |-> !extAccessGrant)
    else $error("external access while locked");
  chk_erase_first: assert property (@(posedge clk) disable iff (srst)
    fullEraseReq |-> !bootClearPulse)
    else $error("flag cleared before erase");
  chk_clear_after: assert property (@(posedge clk) disable iff (srst)
    fullEraseReq && flashEraseDone && !inReset |=> bootClearPulse && !fullEraseReq)
    else $error("flag not cleared after erase");
  chk_keep_clear: assert property (@(posedge clk) disable iff (srst)
    clearBootKeepReq && !clearBootFullReq && !fullEraseReq && !inReset |=> bootClearPulse)
    else $error("keep clear not taken");
  chk_sector_two: assert property (@(posedge clk) disable iff (srst)
    progAddr == UserAppStart |-> flashSector == RBS_SEC2 && flashWordAddr == 12'h200)
    else $error("sector decode wrong");
  chk_wait_reset: assert property (@(posedge clk) disable iff (srst)
    $fell(coreResetN) |=> waitStateCtl == WaitCtlReset)
    else $error("wait control not reset");
  chk_serial_sel: assert property (@(posedge clk) disable iff (srst)
    dataWr && dataAddr == SysCtlAddr && !inReset |=> serialPortMode == $past(dataWrData[10]))
    else $error("serial select not taken");
  chk_periph_merge: assert property (@(posedge clk) disable iff (srst)
    coreResetN && (irqReq[15:5] & irqMask[15:5]) != 11'h000 |-> peripheralIrqLine)
    else $error("peripheral irq lost");
  chk_cycle_out: assert property (@(posedge clk) disable iff (srst)
    cycleClockOut |=> !cycleClockOut)
    else $error("cycle clock stuck");
  chk_hold_length: assert property (@(posedge clk) disable iff (srst)
    $rose(coreResetN) |-> supGoodCnt_r[PorCntW])
    else $error("reset released before hold ended");
  chk_boot_once: assert property (@(posedge clk) disable iff (srst)
    bootVectorValid |=> !bootVectorValid)
    else $error("boot decision repeated");
  chk_wait_write: assert property (@(posedge clk) disable iff (srst)
    dataWr && dataAddr == WaitCtlAddr && !inReset |=> waitStateCtl == $past(dataWrData))
    else $error("wait control write lost");

  // Main scenarios the bench should reach
  cov_flash_boot: cover property (@(posedge clk) bootVectorValid && !extBootStart);
  cov_pin_reset:  cover property (@(posedge clk) $fell(pinSync2_r));
  cov_ext_boot:   cover property (@(posedge clk) bootVectorValid && extBootStart);
  cov_full_clear: cover property (@(posedge clk) fullEraseReq ##[1:20] bootClearPulse);
  cov_periph_irq: cover property (@(posedge clk) peripheralIrqLine);

endmodule

// File: verilog/rbs_pkg.sv
// Package: constants for the reset, boot and system control block
package rbs_pkg;
  localparam int          PorHoldCycles   = 65536;
  localparam int          PorCntW         = 16;
  localparam logic [13:0] MonitorEntry    = 14'h0800;
  localparam logic [13:0] UserAppStart    = 14'h2200;
  localparam logic [13:0] FlashSec0Base   = 14'h2000;
  localparam logic [13:0] FlashSec0Last   = 14'h20FF;
  localparam logic [13:0] FlashSec1Base   = 14'h2100;
  localparam logic [13:0] FlashSec1Last   = 14'h21FF;
  localparam logic [13:0] FlashSec2Base   = 14'h2200;
  localparam logic [13:0] FlashSec2Last   = 14'h2FFF;
  localparam logic [13:0] PeriphBase      = 14'h2000;
  localparam logic [13:0] PeriphLast      = 14'h20FF;
  localparam logic [13:0] WaitCtlAddr     = 14'h3FFE;
  localparam logic [13:0] SysCtlAddr      = 14'h3FFF;
  localparam logic [15:0] WaitCtlReset    = 16'hFFFF;
  localparam logic [15:0] WaitCtlRequired = 16'h8000;
  localparam logic [15:0] SysCtlReset     = 16'h0000;
  localparam int          SerialSelBit    = 10;
  localparam int          NumIrqSrc       = 16;
  localparam int          NumPeriphIrq    = 11;
  localparam int          NumCoreIrq      = 5;
  localparam logic [7:0]  NvByteErased    = 8'h00;
  typedef enum logic [1:0] {RBS_SEC0, RBS_SEC1, RBS_SEC2, RBS_NOSEC} rbs_sector_t;
endpackage

// File: testbench/rbs_system_control_bench.sv
// Self-checking bench for the reset, boot and system control block
`timescale 1ns/100ps
module rbs_system_control_bench;
  import rbs_pkg::*;
  logic        clk, srst, supplyLowN, resetPinN, bootFlashFlag, flashEraseDone;
  logic        clearBootFullReq, clearBootKeepReq, dataWr, dataRd, extAccessReq;
  logic [13:0] progAddr, dataAddr, vecSeen;
  logic [15:0] dataWrData, irqReq, irqMask, dataRdData, waitStateCtl;
  logic        coreResetN, stacksEmpty, irqMaskAll, modeStatusClr, bootVectorValid;
  logic        extBootStart, extAccessGrant, fullEraseReq, bootClearPulse, periphSel;
  logic        serialPortMode, peripheralIrqLine, irqPending, cycleClockOut, extSeen, c0;
  logic [13:0] bootVector;
  logic [1:0]  flashSector;
  logic [11:0] flashWordAddr;
  logic [3:0]  irqVector;
  logic [7:0]  nvUserByte;
  int          fails, checksDone, cycles, n, bootSeen;
  logic [13:0] pa [8] = '{14'h2000, 14'h20FF, 14'h2100, 14'h21FF, 14'h2200, 14'h2FFF,
                          14'h1FFF, 14'h3000};
  logic [1:0]  ps [8] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
  logic [7:0]  pp = 8'h03;

  rbs_system_control DUT (.clk(clk), .srst(srst), .supplyLowN(supplyLowN),
    .resetPinN(resetPinN), .bootFlashFlag(bootFlashFlag), .flashEraseDone(flashEraseDone),
    .clearBootFullReq(clearBootFullReq), .clearBootKeepReq(clearBootKeepReq),
    .progAddr(progAddr), .dataAddr(dataAddr), .dataWr(dataWr), .dataRd(dataRd),
    .dataWrData(dataWrData), .irqReq(irqReq), .irqMask(irqMask),
    .extAccessReq(extAccessReq), .coreResetN(coreResetN), .stacksEmpty(stacksEmpty),
    .irqMaskAll(irqMaskAll), .modeStatusClr(modeStatusClr),
    .bootVectorValid(bootVectorValid), .bootVector(bootVector),
    .extBootStart(extBootStart), .extAccessGrant(extAccessGrant),
    .fullEraseReq(fullEraseReq), .bootClearPulse(bootClearPulse),
    .flashSector(flashSector), .flashWordAddr(flashWordAddr), .periphSel(periphSel),
    .dataRdData(dataRdData), .serialPortMode(serialPortMode),
    .waitStateCtl(waitStateCtl), .peripheralIrqLine(peripheralIrqLine),
    .irqVector(irqVector), .irqPending(irqPending), .cycleClockOut(cycleClockOut),
    .nvUserByte(nvUserByte));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task summarize;
    $display("checks %0d mismatches %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chkVal(input logic [15:0] got, input logic [15:0] exp);
    checksDone++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chkBit(input logic got, input logic exp);
    chkVal({15'h0000, got}, {15'h0000, exp});
  endtask
  // Bench writes only the two control words, never the flash interface
  task wr(input logic [13:0] a, input logic [15:0] d);
    @(posedge clk); dataAddr <= a; dataWrData <= d; dataWr <= 1'b1;
    @(posedge clk); dataWr <= 1'b0; #1;
  endtask
  task rd(input logic [13:0] a, input logic [15:0] exp);
    @(posedge clk); dataAddr <= a; dataRd <= 1'b1;
    @(posedge clk); dataRd <= 1'b0; #1; chkVal(dataRdData, exp);
  endtask

  // Boot pulse lasts one cycle, so catch it whenever it comes
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (bootVectorValid === 1'b1) begin
      bootSeen <= bootSeen + 1;
      vecSeen <= bootVector;
      extSeen <= extBootStart;
    end
    // Ceiling: one power-on hold plus a short tail of tests
    if (cycles == 80000) begin
      fails++;
      summarize;
    end
  end

  initial begin
    {srst, resetPinN, irqMask} = {1'b1, 1'b1, 16'hFFFF};
    {supplyLowN, bootFlashFlag, flashEraseDone, clearBootFullReq, clearBootKeepReq} = '0;
    {dataWr, dataRd, extAccessReq, progAddr, dataAddr, dataWrData, irqReq} = '0;
    {fails, checksDone, cycles, bootSeen} = '0;
    repeat (16) @(posedge clk);
    srst <= 1'b0; supplyLowN <= 1'b1;
    #1; chkVal(16'({stacksEmpty, irqMaskAll, modeStatusClr}), 16'h0007);
    n = 0;
    while (coreResetN !== 1'b1 && n < 70000) begin
      @(posedge clk); #1; n++;
    end
    chkBit(n >= 65536 && n <= 65545, 1'b1);
    repeat (4) @(posedge clk); #1;
    chkVal(16'(bootSeen), 16'h0001);
    chkVal(16'(vecSeen), 16'(MonitorEntry));
    chkBit(extSeen, 1'b1);
    rd(WaitCtlAddr, WaitCtlReset);
    rd(SysCtlAddr, SysCtlReset);
    rd(14'h3800, 16'h0000);
    wr(SysCtlAddr, 16'h0400); chkBit(serialPortMode, 1'b1);
    rd(SysCtlAddr, 16'h0400);
    wr(WaitCtlAddr, WaitCtlRequired); chkVal(waitStateCtl, 16'h8000);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk); progAddr <= pa[i]; dataAddr <= pa[i]; #1;
      chkVal(16'(flashSector), 16'(ps[i]));
      if (ps[i] != 2'h3) chkVal(16'(flashWordAddr), 16'(pa[i] - 14'h2000));
      chkBit(periphSel, pp[i]);
    end
    @(posedge clk); irqReq <= 16'h0020; #1; chkBit(peripheralIrqLine, 1'b1);
    @(posedge clk); irqMask <= 16'hFFDF; #1; chkBit(peripheralIrqLine, 1'b0);
    @(posedge clk); irqReq <= 16'h0030; irqMask <= 16'hFFFF;
    @(posedge clk); irqMask <= 16'hFFEF; #1; chkVal(16'(irqVector), 16'h0004);
    chkBit(irqPending, 1'b1);
    @(posedge clk); #1; chkVal(16'(irqVector), 16'h0005);
    @(posedge clk); irqReq <= 16'h0010; #1; chkBit(peripheralIrqLine, 1'b0);
    @(posedge clk); extAccessReq <= 1'b1; #1; chkBit(extAccessGrant, 1'b1);
    @(posedge clk); bootFlashFlag <= 1'b1; #1; chkBit(extAccessGrant, 1'b0);
    @(posedge clk); clearBootKeepReq <= 1'b1;
    @(posedge clk); clearBootKeepReq <= 1'b0; #1; chkBit(bootClearPulse, 1'b1);
    @(posedge clk); clearBootFullReq <= 1'b1;
    @(posedge clk); clearBootFullReq <= 1'b0; clearBootKeepReq <= 1'b1;
    #1; chkBit(fullEraseReq, 1'b1);
    @(posedge clk); clearBootKeepReq <= 1'b0; #1; chkBit(bootClearPulse, 1'b0);
    @(posedge clk); flashEraseDone <= 1'b1; #1; chkBit(bootClearPulse, 1'b0);
    @(posedge clk); flashEraseDone <= 1'b0; #1; chkBit(bootClearPulse, 1'b1);
    chkBit(fullEraseReq, 1'b0);
    chkVal(16'(nvUserByte), 16'(NvByteErased));
    c0 = cycleClockOut;
    @(posedge clk); #1; chkBit(cycleClockOut, ~c0);
    wr(SysCtlAddr, 16'h0400);
    @(posedge clk); resetPinN <= 1'b0;
    repeat (6) @(posedge clk); #1;
    chkBit(coreResetN, 1'b0);
    chkVal(16'({irqMaskAll, serialPortMode}), 16'h0002);
    chkVal(waitStateCtl, WaitCtlReset);
    @(posedge clk); resetPinN <= 1'b1;
    n = 0;
    while (bootSeen < 2 && n < 70000) begin
      @(posedge clk); #1; n++;
    end
    chkVal(16'(vecSeen), 16'(UserAppStart));
    chkBit(extSeen, 1'b0);
    summarize;
  end
endmodule
